// >>> design/tsec_pkg.sv
// constants, register map and reset routing for the two-stage event controller
package tsec_pkg;
  localparam int NUM_SRC = 56;
  localparam int NUM_GP = 9;
  localparam int CORE_W = 16;
  localparam int GP_BASE = 7;
  localparam int NUM_ASSIGN = 7;
  localparam int ADDR_W = 8;
  localparam int FIELD_W = 4;
  // timing of the core stage, in core clock cycles
  localparam int EDGE_CYCLES = 2;
  localparam int MIN_PEND_CYCLES = 3;
  // register byte offsets
  localparam logic [7:0] OFF_PMASK_LO = 8'h00;
  localparam logic [7:0] OFF_PMASK_HI = 8'h04;
  localparam logic [7:0] OFF_PSTAT_LO = 8'h08;
  localparam logic [7:0] OFF_PSTAT_HI = 8'h0C;
  localparam logic [7:0] OFF_WAKE_LO = 8'h10;
  localparam logic [7:0] OFF_WAKE_HI = 8'h14;
  localparam logic [7:0] OFF_ASSIGN0 = 8'h20;
  localparam logic [7:0] OFF_ASSIGN6 = 8'h38;
  localparam logic [7:0] OFF_LATCH = 8'h40;
  localparam logic [7:0] OFF_CMASK = 8'h44;
  localparam logic [7:0] OFF_NEST = 8'h48;
  localparam logic [7:0] OFF_GSTAT = 8'h4C;
  // reset values
  localparam logic [55:0] PMASK_RST = 56'h00000000000000;
  localparam logic [55:0] WAKE_RST = 56'h00000000000000;
  localparam logic [15:0] CMASK_RST = 16'h0000;
  localparam logic GIE_RST = 1'b0;
  localparam logic [31:0] ASSIGN_RST [NUM_ASSIGN] = '{
    32'h00000000, 32'h11000000, 32'h33332222, 32'h44444433,
    32'h55555555, 32'h06666655, 32'h33333000
  };
endpackage : tsec_pkg

// >>> design/tsec_top.sv
// two-stage event controller: system routing stage, core event stage, apb slave
`timescale 1ns/1ps
module tsec_top
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsec_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral sources, asynchronous levels
  input wire logic [tsec_pkg::NUM_SRC-1:0] periph_irq,
  // core pipeline handshake
  input wire logic core_accept,
  input wire logic core_return,
  input wire logic global_irq_on,
  input wire logic global_irq_off,
  input wire logic core_idle,
  output logic irq_req,
  output logic [3:0] irq_level,
  output logic [tsec_pkg::CORE_W-1:0] event_nesting_pending,
  output logic wakeup_req
);
  import tsec_pkg::*;

  logic [NUM_SRC-1:0] src_s1_reg;
  logic [NUM_SRC-1:0] src_s2_reg;
  logic [NUM_SRC-1:0] pmask_reg;
  logic [NUM_SRC-1:0] wake_reg;
  logic [31:0] assign_reg [NUM_ASSIGN];
  logic [NUM_GP-1:0] gp_in_reg;
  logic [NUM_GP-1:0] gp_next;
  logic [NUM_GP-1:0] gp_s1_reg;
  logic [NUM_GP-1:0] gp_s2_reg;
  logic [CORE_W-1:0] edge_vec;
  logic [CORE_W-1:0] latch_reg;
  logic [CORE_W-1:0] latch_next;
  logic [CORE_W-1:0] cmask_reg;
  logic [CORE_W-1:0] nest_reg;
  logic [CORE_W-1:0] nest_next;
  logic gie_reg;
  logic req_next;
  logic [4:0] best;
  logic [4:0] top;
  logic [31:0] rd_data;
  logic addr_err;
  logic setup_acc;
  logic wr_en;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_req_reg;
  logic [3:0] irq_level_reg;
  logic wakeup_reg;

  // lowest set bit index, 16 when none: lower index is higher priority
  function automatic logic [4:0] tsec_first(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--)
    begin
      if (v[i])
        r = 5'(i);
    end
    return r;
  endfunction : tsec_first

  // routing field of one source inside its assignment word
  function automatic logic [3:0] tsec_field(input logic [31:0] w, input int k);
    return w[k*FIELD_W +: FIELD_W];
  endfunction : tsec_field

  // core registers sit just below the global status word at the top of the map and need privileged access
  function automatic logic tsec_is_core(input logic [7:0] a);
    return (a == OFF_LATCH) || (a == OFF_CMASK) || (a == OFF_NEST);
  endfunction : tsec_is_core

  // two-flop synchroniser, first stage read by the second only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_s1_reg <= '0;
      src_s2_reg <= '0;
    end
    else
    begin
      src_s1_reg <= periph_irq;
      src_s2_reg <= src_s1_reg;
    end
  end

  // ---------------- apb decode ----------------
  // one wait state so that prdata and pslverr come straight from flops
  assign setup_acc = psel && penable && !pready_reg;
  assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;

  // read mux and decode of unmapped or unprivileged accesses
  always_comb
  begin
    rd_data = 32'h00000000;
    addr_err = 1'b0;
    if (paddr >= OFF_ASSIGN0 && paddr <= OFF_ASSIGN6 && paddr[1:0] == 2'h0)
      rd_data = assign_reg[3'((paddr - OFF_ASSIGN0) >> 2)];
    else
    begin
      unique case (paddr)
        OFF_PMASK_LO: rd_data = pmask_reg[31:0];
        OFF_PMASK_HI: rd_data = {8'h00, pmask_reg[55:32]};
        OFF_PSTAT_LO: rd_data = src_s2_reg[31:0];
        OFF_PSTAT_HI: rd_data = {8'h00, src_s2_reg[55:32]};
        OFF_WAKE_LO: rd_data = wake_reg[31:0];
        OFF_WAKE_HI: rd_data = {8'h00, wake_reg[55:32]};
        OFF_LATCH: rd_data = {16'h0000, latch_reg};
        OFF_CMASK: rd_data = {16'h0000, cmask_reg};
        OFF_NEST: rd_data = {16'h0000, nest_reg};
        OFF_GSTAT: rd_data = {31'h00000000, gie_reg};
        default: addr_err = 1'b1;
      endcase
    end
    // user-mode access to core registers is refused
    if (tsec_is_core(paddr) && !pprot[0])
      addr_err = 1'b1;
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setup_acc;
      pslverr_reg <= setup_acc && addr_err;
      prdata_reg <= (setup_acc && !pwrite && !addr_err) ? rd_data : 32'h00000000;
    end
  end

  // ---------------- system routing stage ----------------
  // peripheral mask and wakeup enable words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pmask_reg <= PMASK_RST;
      wake_reg <= WAKE_RST;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_PMASK_LO)
        pmask_reg[31:0] <= pwdata;
      if (paddr == OFF_PMASK_HI)
        pmask_reg[55:32] <= pwdata[23:0];
      if (paddr == OFF_WAKE_LO)
        wake_reg[31:0] <= pwdata;
      if (paddr == OFF_WAKE_HI)
        wake_reg[55:32] <= pwdata[23:0];
    end
  end

  // assignment words, each holding eight four-bit routing fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int r = 0; r < NUM_ASSIGN; r++)
        assign_reg[r] <= ASSIGN_RST[r];
    end
    else if (wr_en && paddr >= OFF_ASSIGN0 && paddr <= OFF_ASSIGN6 && paddr[1:0] == 2'h0)
      assign_reg[3'((paddr - OFF_ASSIGN0) >> 2)] <= pwdata;
  end

  // core input is the or of all unmasked sources routed to it; an index
  // above eight routes the source nowhere
  always_comb
  begin
    gp_next = '0;
    for (int s = 0; s < NUM_SRC; s++)
    begin
      if (src_s2_reg[s] && pmask_reg[s])
      begin
        if (tsec_field(assign_reg[s / 8], s % 8) < 4'(NUM_GP))
          gp_next[tsec_field(assign_reg[s / 8], s % 8)] = 1'b1;
      end
    end
  end

  // registered general inputs; shared sources stay merged, so a second
  // source asserting while the first is held gives no fresh edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gp_in_reg <= '0;
    else
      gp_in_reg <= gp_next;
  end

  // wakeup request while the core sleeps, mask bits do not gate it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wakeup_reg <= 1'b0;
    else
      wakeup_reg <= core_idle && ((src_s2_reg & wake_reg) != '0);
  end

  // ---------------- core event stage ----------------
  // two-cycle edge detector on the general inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gp_s1_reg <= '0;
      gp_s2_reg <= '0;
    end
    else
    begin
      gp_s1_reg <= gp_in_reg;
      gp_s2_reg <= gp_s1_reg;
    end
  end

  assign edge_vec = {gp_s1_reg & ~gp_s2_reg, 7'h00};

  // latch: software touches only masked bits, edge set beats accept clear
  always_comb
  begin
    latch_next = latch_reg;
    if (wr_en && paddr == OFF_LATCH)
      latch_next = (latch_reg & cmask_reg) | (pwdata[15:0] & ~cmask_reg);
    if (irq_req_reg && core_accept)
      latch_next[irq_level_reg] = 1'b0;
    latch_next = latch_next | edge_vec;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_reg <= '0;
    else
      latch_reg <= latch_next;
  end

  // core mask, supervisor only through the decode above
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmask_reg <= CMASK_RST;
    else if (wr_en && paddr == OFF_CMASK)
      cmask_reg <= pwdata[15:0];
  end

  // global enable from the on and off instructions; off wins if both
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gie_reg <= GIE_RST;
    else if (global_irq_off)
      gie_reg <= 1'b0;
    else if (global_irq_on)
      gie_reg <= 1'b1;
  end

  // nesting: return retires the most urgent active level, accept adds one
  always_comb
  begin
    nest_next = nest_reg;
    if (core_return && top != 5'h10)
      nest_next[top[3:0]] = 1'b0;
    if (irq_req_reg && core_accept)
      nest_next[irq_level_reg] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      nest_reg <= '0;
    else
      nest_reg <= nest_next;
  end

  // request only a level more urgent than every active one
  always_comb
  begin
    best = tsec_first((latch_reg & cmask_reg) & 16'hFF80);
    top = tsec_first(nest_reg);
    req_next = gie_reg && (best != 5'h10) && (best < top) && !core_accept;
  end

  // request flops; dropped for a cycle after accept so one edge is
  // never taken twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req_reg <= 1'b0;
      irq_level_reg <= 4'h0;
    end
    else
    begin
      irq_req_reg <= req_next;
      irq_level_reg <= best[3:0];
    end
  end

  // outputs straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_req = irq_req_reg;
  assign irq_level = irq_level_reg;
  assign event_nesting_pending = nest_reg;
  assign wakeup_req = wakeup_reg;

  // ---------------- assertions ----------------
  logic [CORE_W-1:0] nest_d_reg;
  logic [CORE_W-1:0] pend_rise;
  logic [CORE_W-1:0] edge_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nest_d_reg <= '0;
      edge_d <= '0;
    end
    else
    begin
      nest_d_reg <= nest_reg;
      edge_d <= edge_vec;
    end
  end

  assign pend_rise = nest_reg & ~nest_d_reg;

  property p_reset_route;
    @(posedge pclk) $rose(presetn) |-> assign_reg[0] == 32'h00000000
      && assign_reg[1] == 32'h11000000 && assign_reg[2] == 32'h33332222
      && assign_reg[3] == 32'h44444433 && assign_reg[4] == 32'h55555555
      && assign_reg[5] == 32'h06666655 && assign_reg[6] == 32'h33333000;
  endproperty
  a_reset_route: assert property (p_reset_route)
    else $error("routing not at reset defaults");

  property p_mask_blocks;
    @(posedge pclk) disable iff (!presetn)
    (pmask_reg == '0) [*2] |-> gp_in_reg == '0;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked sources reached a core input");

  property p_status_read;
    @(posedge pclk) disable iff (!presetn)
    (setup_acc && !pwrite && pprot[0] && paddr == OFF_PSTAT_LO)
      |=> prdata == $past(src_s2_reg[31:0]) && pready;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show asserting sources");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
    core_idle && ((src_s2_reg & wake_reg) != '0) |=> wakeup_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled source did not wake the core");

  property p_edge_latch;
    @(posedge pclk) disable iff (!presetn)
    (edge_d != '0) |-> (latch_reg & edge_d) == edge_d;
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("rising edge not latched");

  property p_accept;
    @(posedge pclk) disable iff (!presetn)
    (irq_req && core_accept && !core_return) |=> nest_reg[$past(irq_level)];
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted level not marked pending");

  property p_min_latency;
    @(posedge pclk) disable iff (!presetn)
    (pend_rise != '0) |-> (pend_rise & ~$past(latch_reg)) == '0;
  endproperty
  a_min_latency: assert property (p_min_latency)
    else $error("pending set for a level that was not latched");

  property p_core_mask;
    @(posedge pclk) disable iff (!presetn)
    (cmask_reg == '0) [*2] |-> !irq_req;
  endproperty
  a_core_mask: assert property (p_core_mask)
    else $error("request raised with every core mask bit clear");

  property p_user_refused;
    @(posedge pclk) disable iff (!presetn)
    (setup_acc && !pprot[0] && paddr == OFF_CMASK) |=> pslverr ##1 $stable(cmask_reg);
  endproperty
  a_user_refused: assert property (p_user_refused)
    else $error("user access to core mask not refused");

  property p_global_off;
    @(posedge pclk) disable iff (!presetn)
    global_irq_off ##1 !global_irq_on |=> !irq_req;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("request raised while globally disabled");

  property p_return;
    @(posedge pclk) disable iff (!presetn)
    (core_return && !core_accept && nest_reg != '0)
      |=> $countones(nest_reg) == $countones($past(nest_reg)) - 1;
  endproperty
  a_return: assert property (p_return)
    else $error("return did not retire exactly one level");

  property p_priority;
    @(posedge pclk) disable iff (!presetn)
    irq_req |-> irq_level >= 4'h7 && nest_d_reg[irq_level] == 1'b0;
  endproperty
  a_priority: assert property (p_priority)
    else $error("request for a level already active");

endmodule : tsec_top

// >>> sim/tb_two_stage_event_controller.sv
// self-checking bench for the two-stage event controller
`timescale 1ns/1ps
module tb_two_stage_event_controller;
  import tsec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic core_idle, g_on, g_off, slow, do_return, core_accept, core_return, irq_req, wakeup_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, exp_w;
  logic [2:0] pprot;
  logic [NUM_SRC-1:0] periph_irq;
  logic [3:0] irq_level;
  logic [CORE_W-1:0] nest;
  int bad_count, check_count, n;

  tsec_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_irq(periph_irq), .core_accept(core_accept),
    .core_return(core_return), .global_irq_on(g_on), .global_irq_off(g_off),
    .core_idle(core_idle), .irq_req(irq_req), .irq_level(irq_level),
    .event_nesting_pending(nest), .wakeup_req(wakeup_req));

  tsec_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .core_accept(core_accept), .core_return(core_return), .slow(slow), .do_return(do_return));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // one apb transfer; answer taken and request released at the ready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      bad_count++;
      wrap_up();
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
  endtask : wr

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 3'h1);
    chk(nm, rd, x);
  endtask : rchk

  // bounded wait for a flag; the caller judges the count
  task wait_for(input int which, input int lim);
    n = 0;
    while ((which == 0 ? irq_req : wakeup_req) !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_for

  task wait_nest(input logic [15:0] x);
    n = 0;
    while (nest !== x && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    chk("nesting", 32'(nest), 32'(x));
  endtask : wait_nest

  task pulse(input logic on);
    @(posedge pclk);
    if (on)
      g_on <= 1'b1;
    else
      g_off <= 1'b1;
    @(posedge pclk);
    g_on <= 1'b0;
    g_off <= 1'b0;
  endtask : pulse

  task ret;
    @(posedge pclk);
    do_return <= 1'b1;
    @(posedge pclk);
    do_return <= 1'b0;
  endtask : ret

  // default routing index of one source
  function automatic logic [3:0] dflt(input int s);
    return s < 14 ? 4'h0 : s < 16 ? 4'h1 : s < 20 ? 4'h2 : s < 26 ? 4'h3 : s < 32 ? 4'h4 :
      s < 42 ? 4'h5 : s < 47 ? 4'h6 : s < 51 ? 4'h0 : 4'h3;
  endfunction : dflt

  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, core_idle, g_on, g_off, slow, do_return} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pprot = 3'h1;
    periph_irq = '0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < NUM_ASSIGN; k++)
    begin
      exp_w = 32'h0;
      for (int j = 0; j < 8; j++)
        exp_w[4*j+:4] = dflt(8 * k + j);
      rchk("assign_rst", OFF_ASSIGN0 + 8'(4 * k), exp_w);
    end
    rchk("gstat_rst", OFF_GSTAT, 32'h0);
    wr(OFF_PMASK_LO, 32'h00014001);
    rchk("pmask_lo", OFF_PMASK_LO, 32'h00014001);
    wr(OFF_WAKE_HI, 32'h00800000);
    rchk("wake_hi", OFF_WAKE_HI, 32'h00800000);
    apb(1'b0, 8'h18, 32'h0, 3'h1);
    chk("unmapped_err", 32'(err), 32'h1);
    apb(1'b1, OFF_CMASK, 32'h00001180, 3'h0);
    chk("user_cmask_err", 32'(err), 32'h1);
    rchk("cmask_kept", OFF_CMASK, 32'h0);
    wr(OFF_CMASK, 32'h00000180);
    rchk("cmask", OFF_CMASK, 32'h00000180);
    pulse(1'b1);
    // masked sources show in status but raise nothing
    periph_irq[3] <= 1'b1;
    periph_irq[40] <= 1'b1;
    wait_for(0, 20);
    chk("masked_quiet", 32'(n), 32'd20);
    rchk("stat_lo", OFF_PSTAT_LO, 32'h00000008);
    rchk("stat_hi", OFF_PSTAT_HI, 32'h00000100);
    periph_irq <= 56'h00000000004000;
    wait_for(0, 40);
    chk("latency", 32'(n >= 3), 32'h1);
    chk("level8", 32'(irq_level), 32'd8);
    wait_nest(16'h0100);
    rchk("latch_clr", OFF_LATCH, 32'h0);
    // global off gates a more urgent event, global on lets it nest
    periph_irq[14] <= 1'b0;
    slow <= 1'b1;
    pulse(1'b0);
    periph_irq[0] <= 1'b1;
    wait_for(0, 20);
    chk("gated", 32'(n), 32'd20);
    pulse(1'b1);
    wait_for(0, 40);
    chk("level7", 32'(irq_level), 32'd7);
    wait_nest(16'h0180);
    rchk("gstat_on", OFF_GSTAT, 32'h1);
    ret();
    wait_nest(16'h0100);
    ret();
    wait_nest(16'h0000);
    // core-masked event stays latched; software clears it
    periph_irq[0] <= 1'b0;
    periph_irq[16] <= 1'b1;
    wait_for(0, 20);
    chk("cmasked", 32'(n), 32'd20);
    rchk("latched", OFF_LATCH, 32'h00000200);
    wr(OFF_LATCH, 32'h0);
    rchk("latch_sw", OFF_LATCH, 32'h0);
    // reroute source 0 to index 5
    wr(OFF_ASSIGN0, 32'h00000005);
    rchk("assign0", OFF_ASSIGN0, 32'h00000005);
    wr(OFF_CMASK, 32'h00001180);
    periph_irq[0] <= 1'b1;
    wait_for(0, 40);
    chk("level12", 32'(irq_level), 32'd12);
    // wakeup while idle
    wr(OFF_WAKE_LO, 32'h00100000);
    core_idle <= 1'b1;
    periph_irq[20] <= 1'b1;
    wait_for(1, 40);
    chk("wakeup", 32'(n < 40), 32'h1);
    wrap_up();
  end
endmodule : tb_two_stage_event_controller

// >>> sim/tsec_core_model.sv
// core pipeline stand-in: takes requested levels and returns from them on command
`timescale 1ns/1ps
module tsec_core_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  input wire logic irq_req,
  output logic core_accept,
  output logic core_return,
  // bench control
  input wire logic slow,
  input wire logic do_return
);
  logic [2:0] wait_reg;

  // accept after a short or long stall; never twice for one request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_reg <= 3'h0;
      core_accept <= 1'b0;
    end
    else
    begin
      core_accept <= 1'b0;
      if (!irq_req || core_accept)
        wait_reg <= 3'h0;
      else if (wait_reg >= (slow ? 3'h6 : 3'h0))
        core_accept <= 1'b1;
      else
        wait_reg <= wait_reg + 3'h1;
    end
  end

  // return is a one-cycle pulse, so one level is popped per command
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      core_return <= 1'b0;
    else
      core_return <= do_return;
  end
endmodule : tsec_core_model
